// >>> ctrl_link_if.sv
// Three-wire link between the control port host and the device.
`default_nettype none
interface ctrl_link_if;
	logic ctrlPhaseSelectLine;
	logic ctrlSerialClockLine;
	logic hostDataOut;
	logic hostDataOe;
	logic devDataOut;
	logic devDataOe;
	wire  ctrlSerialDataLine;

	// Pull-up keeps the shared data line high when nobody drives it.
	assign ctrlSerialDataLine = hostDataOe ? hostDataOut : (devDataOe ? devDataOut : 1'b1);

	modport host (
		output ctrlPhaseSelectLine,
		output ctrlSerialClockLine,
		output hostDataOut,
		output hostDataOe,
		input  ctrlSerialDataLine
	);

	modport device (
		input  ctrlPhaseSelectLine,
		input  ctrlSerialClockLine,
		output devDataOut,
		output devDataOe,
		input  ctrlSerialDataLine
	);
endinterface
`default_nettype wire

// >>> ctrl_link_props.sv
// Wire-level assertions for the three-wire control link.
`default_nettype none
module ctrl_link_props (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Link
	input wire logic ctrlPhaseSelectLine,
	input wire logic ctrlSerialClockLine,
	input wire logic hostDataOe,
	input wire logic devDataOe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic       sclkPrev;
	logic       modePrev;
	logic [4:0] addrFalls;
	logic [4:0] dataRises;
	logic [4:0] oeRises;
	wire        sclkRise = ctrlSerialClockLine & ~sclkPrev;
	wire        sclkFall = sclkPrev & ~ctrlSerialClockLine;
	wire        modeFall = modePrev & ~ctrlPhaseSelectLine;

	// Phase counters restart at every fall of the mode line, the drive counter while the device is not driving; a short or long burst shows at the next change.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclkPrev <= 1'b1;
			modePrev <= 1'b1;
			addrFalls <= 5'h00;
			dataRises <= 5'h00;
			oeRises <= 5'h00;
		end else begin
			sclkPrev <= ctrlSerialClockLine;
			modePrev <= ctrlPhaseSelectLine;
			addrFalls <= modeFall ? 5'h00 : addrFalls + 5'((!ctrlPhaseSelectLine && sclkFall) ? 1 : 0);
			dataRises <= modeFall ? 5'h00 : dataRises + 5'((ctrlPhaseSelectLine && sclkRise) ? 1 : 0);
			oeRises <= !devDataOe ? 5'h00 : oeRises + 5'(sclkRise ? 1 : 0);
		end
	end

	no_clash_a: assert property (!(hostDataOe && devDataOe))
		else $error("both ends drive the data line");
	mode_clk_high_a: assert property ($changed(ctrlPhaseSelectLine) |-> ctrlSerialClockLine && $past(ctrlSerialClockLine))
		else $error("mode line changed while the serial clock was low");
	addr_eight_a: assert property ($rose(ctrlPhaseSelectLine) |-> addrFalls == 5'h08)
		else $error("address phase did not carry eight clock pulses");
	data_count_a: assert property ($fell(ctrlPhaseSelectLine) |-> dataRises inside {5'h00, 5'h08, 5'h18})
		else $error("data phase ended after an odd bit count");
	oe_start_a: assert property ($rose(devDataOe) |-> ctrlPhaseSelectLine && !hostDataOe)
		else $error("device took the data line outside a data phase");
	oe_length_a: assert property ($fell(devDataOe) |-> oeRises == 5'h18)
		else $error("device drive did not span three bytes");
	clk_low_a: assert property ($fell(ctrlSerialClockLine) |-> (!ctrlSerialClockLine)[*4])
		else $error("serial clock low pulse too short");
	oe_release_a: assert property ($fell(ctrlPhaseSelectLine) |-> ##[0:4] !devDataOe)
		else $error("device kept driving into an address phase");
endmodule
`default_nettype wire

// >>> ctrl_port_device.sv
// Device end: decodes address and data phases, writes registers, answers reads.
//
// Decided for this implementation: the plain strobed port and the register offsets.
`default_nettype none
module ctrl_port_device
	import ctrl_port_pkg::*;
(
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// Link
	ctrl_link_if.device                    link,
	// Address strap
	input  wire logic                      addressSelectPin,
	// Register write port
	output logic                           regWrStrobe,
	output logic [REG_ADDR_BITS-1:0]       regWrAddr,
	output logic [WORD_BITS-1:0]           regWrData,
	// Register read port
	output logic [REG_ADDR_BITS-1:0]       regRdAddr,
	input  wire logic [WORD_BITS-1:0]      regRdData,
	input  wire logic                      regRdValid
);
	typedef enum logic [1:0] {
		SEL_NONE  = 2'b00,
		SEL_WRITE = 2'b01,
		SEL_READ  = 2'b10
	} sel_state_t;

	sel_state_t                 selState;
	logic [2:0]                 modeSync;
	logic [2:0]                 clockSync;
	logic [1:0]                 dataSync;
	logic [1:0]                 strapSync;
	logic [POS_BITS-1:0]        bitPos;
	logic [WORD_BITS-1:0]       rxShift;
	logic [RESP_BITS-1:0]       txShift;
	logic                       writeArmed;
	logic                       driving;

	// Bit zero of each synchroniser is the raw first stage; only the
	// next stage reads it, all decoding looks at the later stages.
	wire modeLevel  = modeSync[1];
	wire modeEdge   = modeSync[1] ^ modeSync[2];
	wire clockRise  = clockSync[1] & ~clockSync[2];
	wire clockFall  = ~clockSync[1] & clockSync[2];
	wire dataBit    = dataSync[1];
	wire addrSelect = strapSync[1];

	// Byte assembled with the first bit in time at the top.
	wire [BYTE_BITS-1:0] rxByte = {rxShift[BYTE_BITS-2:0], dataBit};
	wire [WORD_BITS-1:0] rxWord = {rxShift[WORD_BITS-2:0], dataBit};
	wire [1:0] typeField = rxByte[7:6];
	wire addrMatch = (rxByte[5:0] == {addrSelect, DEV_ADDR_FIXED});
	wire regRwFlag = rxByte[7];
	wire [REG_ADDR_BITS-1:0] regAddrField = rxByte[6:0];
	wire typeWrite = (typeField == TYPE_WRITE);
	wire typeRead  = (typeField == TYPE_READ);

	wire addrByteDone = clockRise && !modeLevel && bitPos == LAST_BYTE_POS;
	wire regByteDone  = clockRise && modeLevel && bitPos == LAST_BYTE_POS;
	// A write data phase and the read answer both end at the twenty-fourth rise.
	wire wordDone     = clockRise && modeLevel && bitPos == LAST_RESP_POS;
	wire readStart    = modeEdge && modeLevel && selState == SEL_READ;

	assign link.devDataOut = txShift[RESP_BITS-1];
	assign link.devDataOe  = driving;

	// Flag, address and word as they leave the device, first in time at the top.
	wire respFlag = regRdValid ? FLAG_VALID : FLAG_INVALID;
	wire [RESP_BITS-1:0] respWord = {respFlag, regRdAddr, regRdData};
	wire respLast = (bitPos == LAST_RESP_POS);

	// Two flip-flops on every pin before any logic looks at it.
	// The strap is compared only at the end of an address byte, so a change waits for the next one.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			modeSync <= '1;
			clockSync <= '1;
			dataSync <= '1;
			strapSync <= '0;
		end else begin
			modeSync <= {modeSync[1:0], link.ctrlPhaseSelectLine};
			clockSync <= {clockSync[1:0], link.ctrlSerialClockLine};
			dataSync <= {dataSync[0], link.ctrlSerialDataLine};
			strapSync <= {strapSync[0], addressSelectPin};
		end
	end

	// Any change of the mode line starts a fresh phase, so a stray
	// partial byte never shifts the count of the next one.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bitPos <= '0;
			rxShift <= '0;
		end else if (modeEdge) begin
			bitPos <= '0;
		end else if (clockRise) begin
			rxShift <= rxWord;
			if (bitPos != '1) begin
				bitPos <= bitPos + 1'b1;
			end
		end
	end

	// Selection follows the last complete address byte.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			selState <= SEL_NONE;
		end else if (modeEdge && !modeLevel) begin
			selState <= SEL_NONE;
		end else if (addrByteDone) begin
			if (!addrMatch) begin
				selState <= SEL_NONE;
			end else if (typeWrite) begin
				selState <= SEL_WRITE;
			end else if (typeRead) begin
				selState <= SEL_READ;
			end else begin
				selState <= SEL_NONE;
			end
		end else if (driving && wordDone) begin
			selState <= SEL_NONE;
		end
	end

	// One register address per address byte: after the data word the
	// device waits for a new address byte before writing again.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			writeArmed <= 1'b0;
			regWrAddr <= '0;
			regRdAddr <= '0;
		end else if (modeEdge) begin
			writeArmed <= 1'b0;
		end else if (regByteDone && selState == SEL_WRITE) begin
			if (regRwFlag == RW_WRITE) begin
				regWrAddr <= regAddrField;
				writeArmed <= 1'b1;
			end else begin
				regRdAddr <= regAddrField;
				writeArmed <= 1'b0;
			end
		end else if (wordDone) begin
			writeArmed <= 1'b0;
		end
	end

	// The data word is the two bytes after the register byte, high first.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			regWrStrobe <= 1'b0;
			regWrData <= '0;
		end else begin
			regWrStrobe <= 1'b0;
			if (wordDone && writeArmed && selState == SEL_WRITE) begin
				regWrData <= rxWord;
				regWrStrobe <= 1'b1;
			end
		end
	end

	// Response: flagged register address, then data high and low byte.
	// The word is captured once at the start of the data phase, so a
	// register that changes mid-answer still reads back consistently.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			txShift <= '0;
			driving <= 1'b0;
		end else if (readStart) begin
			txShift <= respWord;
			driving <= 1'b1;
		end else if (modeEdge) begin
			driving <= 1'b0;
		end else if (driving && clockRise) begin
			// The master samples on the rise, so the next bit follows it.
			txShift <= {txShift[RESP_BITS-2:0], 1'b0};
			if (respLast) begin
				driving <= 1'b0;
			end
		end
	end

	// The falling edge is deliberately unused: advancing right after the
	// rise gives the master a whole clock period of setup at its slow rates.
	logic unusedFall;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			unusedFall <= 1'b0;
		end else begin
			unusedFall <= clockFall;
		end
	end
endmodule
`default_nettype wire

// >>> ctrl_port_host.sv
// Host end: drives mode, clock and data and runs write and read transfers.
`default_nettype none
module ctrl_port_host
	import ctrl_port_pkg::*;
#(
	parameter int HALF_CYCLES = LINK_HALF_CYC
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// Link
	ctrl_link_if.host                      link,
	// Command
	input  wire logic                      cmdStart,
	input  wire logic                      cmdRead,
	input  wire logic                      cmdAddrSelect,
	input  wire logic [REG_ADDR_BITS-1:0]  cmdRegAddr,
	input  wire logic [WORD_BITS-1:0]      cmdWriteData,
	// Status
	output logic                           busy,
	output logic                           done,
	output logic                           rspInvalid,
	output logic [REG_ADDR_BITS-1:0]       rspRegAddr,
	output logic [WORD_BITS-1:0]           rspData
);
	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_SETUP = 3'b001,
		H_LOW   = 3'b010,
		H_HIGH  = 3'b011
	} host_state_t;

	host_state_t                state;
	logic [1:0]                 phase;
	logic [HALF_CNT_BITS-1:0]   halfCnt;
	logic [POS_BITS-1:0]        bitPos;
	logic [RESP_BITS-1:0]       txShift;
	logic [RESP_BITS-1:0]       rxShift;
	logic                       opRead;
	logic                       opSel;
	logic [REG_ADDR_BITS-1:0]   opAddr;
	logic [WORD_BITS-1:0]       opData;
	logic                       dataSync1;
	logic                       dataSync2;

	wire halfDone  = (halfCnt == HALF_CNT_BITS'(HALF_CYCLES - 1));
	wire phaseMode = phase[0];
	wire phaseRx   = (phase == PH_RESP);
	wire lastPhase = opRead ? (phase == PH_RESP) : (phase == PH_DATA);
	wire longPhase = (phase == PH_RESP) || (phase == PH_DATA && !opRead);
	wire [POS_BITS-1:0] lastPos = longPhase ? LAST_RESP_POS : LAST_BYTE_POS;
	// Every byte is sent first bit first from the top of the shifter.
	wire [BYTE_BITS-1:0] addrByte = {(phase == PH_READADDR) ? TYPE_READ : TYPE_WRITE,
		opSel, DEV_ADDR_FIXED};
	wire [RESP_BITS-1:0] loadWord =
		phaseMode ? (opRead ? {RW_READ, opAddr, WORD_BITS'(0)}
		                    : {RW_WRITE, opAddr, opData})
		          : {addrByte, WORD_BITS'(0)};

	assign busy = (state != H_IDLE);
	assign link.hostDataOut = txShift[RESP_BITS-1];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dataSync1 <= 1'b1;
			dataSync2 <= 1'b1;
		end else begin
			dataSync1 <= link.ctrlSerialDataLine;
			dataSync2 <= dataSync1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= H_IDLE;
			phase <= PH_ADDR;
			halfCnt <= '0;
			bitPos <= '0;
			txShift <= '0;
			rxShift <= '0;
			opRead <= 1'b0;
			opSel <= 1'b0;
			opAddr <= '0;
			opData <= '0;
			done <= 1'b0;
			rspInvalid <= 1'b0;
			rspRegAddr <= '0;
			rspData <= '0;
			link.ctrlPhaseSelectLine <= 1'b1;
			link.ctrlSerialClockLine <= 1'b1;
			link.hostDataOe <= 1'b0;
		end else begin
			done <= 1'b0;
			halfCnt <= halfDone ? '0 : halfCnt + 1'b1;
			unique case (state)
				H_IDLE: begin
					halfCnt <= '0;
					if (cmdStart) begin
						opRead <= cmdRead;
						opSel <= cmdAddrSelect;
						opAddr <= cmdRegAddr;
						opData <= cmdWriteData;
						phase <= PH_ADDR;
						state <= H_SETUP;
					end
				end
				H_SETUP: begin
					// Mode changes only while the clock rests high.
					link.ctrlPhaseSelectLine <= phaseMode;
					link.hostDataOe <= !phaseRx;
					txShift <= loadWord;
					bitPos <= '0;
					if (halfDone) begin
						link.ctrlSerialClockLine <= 1'b0;
						state <= H_LOW;
					end
				end
				H_LOW: begin
					if (halfDone) begin
						link.ctrlSerialClockLine <= 1'b1;
						rxShift <= {rxShift[RESP_BITS-2:0], dataSync2};
						state <= H_HIGH;
					end
				end
				H_HIGH: begin
					if (halfDone) begin
						if (bitPos != lastPos) begin
							bitPos <= bitPos + 1'b1;
							txShift <= {txShift[RESP_BITS-2:0], 1'b0};
							link.ctrlSerialClockLine <= 1'b0;
							state <= H_LOW;
						end else if (lastPhase) begin
							link.hostDataOe <= 1'b0;
							done <= 1'b1;
							if (opRead) begin
								{rspInvalid, rspRegAddr, rspData} <= rxShift;
							end
							state <= H_IDLE;
						end else begin
							phase <= phase + 1'b1;
							state <= H_SETUP;
						end
					end
				end
				default: state <= H_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> ctrl_port_pkg.sv
// Shared constants for the three-wire serial control port.
`default_nettype none
package ctrl_port_pkg;
	// Widths of the transfer units.
	localparam int BYTE_BITS      = 8;
	localparam int WORD_BITS      = 16;
	localparam int REG_ADDR_BITS  = 7;
	localparam int RESP_BITS      = 24;
	localparam int POS_BITS       = 5;
	// Bit positions count rising serial clock edges from zero.
	localparam logic [4:0] LAST_BYTE_POS = 5'h07;
	localparam logic [4:0] LAST_RESP_POS = 5'h17;
	// Type field as {first bit, second bit} of an address byte.
	localparam logic [1:0] TYPE_WRITE = 2'h1;
	localparam logic [1:0] TYPE_READ  = 2'h3;
	// Address bits three to seven in time order: a one, then four zeros.
	localparam logic [4:0] DEV_ADDR_FIXED = 5'h10;
	// Register-address byte: first bit is the read flag.
	localparam logic RW_WRITE = 1'b0;
	localparam logic RW_READ  = 1'b1;
	localparam logic FLAG_VALID   = 1'b0;
	localparam logic FLAG_INVALID = 1'b1;
	// Host phase indices.
	localparam logic [1:0] PH_ADDR     = 2'h0;
	localparam logic [1:0] PH_DATA     = 2'h1;
	localparam logic [1:0] PH_READADDR = 2'h2;
	localparam logic [1:0] PH_RESP     = 2'h3;
	// Serial clock timing.
	localparam int CLK_PERIOD_NS  = 5;
	localparam int LINK_HALF_NS   = 24;
	localparam int LINK_HALF_CYC  = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HALF_CNT_BITS  = 8;
endpackage
`default_nettype wire

// >>> testbench.sv
// Bench joining host and device ends over the link, checking wire bits and register traffic.
`default_nettype none
module testbench import ctrl_port_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic                     clk = 1'b0;
	logic                     rst_n = 1'b0;
	logic                     cmdStart = 1'b0;
	logic                     cmdRead = 1'b0;
	logic                     cmdAddrSelect = 1'b0;
	logic [REG_ADDR_BITS-1:0] cmdRegAddr = 7'h00;
	logic [WORD_BITS-1:0]     cmdWriteData = 16'h0000;
	logic                     addressSelectPin = 1'b0;
	logic                     busy, done, rspInvalid, regWrStrobe;
	logic [REG_ADDR_BITS-1:0] rspRegAddr, regWrAddr, regRdAddr;
	logic [WORD_BITS-1:0]     rspData, regWrData;
	logic [WORD_BITS-1:0]     mem [128];
	logic [47:0]              bits = 48'h0000_0000_0000;
	logic                     sclkPrev = 1'b1;
	int                       nbits = 0;
	int                       wrCount = 0;
	int                       cycles = 0;
	int                       err_count = 0;
	int                       checks_done = 0;
	// User register file: addresses from 7'h60 up report invalid.
	wire [WORD_BITS-1:0]      regRdData = mem[regRdAddr];
	wire                      regRdValid = regRdAddr < 7'h60;

	ctrl_link_if link ();
	ctrl_port_host ctrl_port_host_i (.clk(clk), .rst_n(rst_n), .link(link.host), .cmdStart(cmdStart),
		.cmdRead(cmdRead), .cmdAddrSelect(cmdAddrSelect), .cmdRegAddr(cmdRegAddr), .cmdWriteData(cmdWriteData),
		.busy(busy), .done(done), .rspInvalid(rspInvalid), .rspRegAddr(rspRegAddr), .rspData(rspData));
	ctrl_port_device ctrl_port_device_i (.clk(clk), .rst_n(rst_n), .link(link.device),
		.addressSelectPin(addressSelectPin), .regWrStrobe(regWrStrobe), .regWrAddr(regWrAddr),
		.regWrData(regWrData), .regRdAddr(regRdAddr), .regRdData(regRdData), .regRdValid(regRdValid));
	ctrl_link_props ctrl_link_props_i (.clk(clk), .rst_n(rst_n), .ctrlPhaseSelectLine(link.ctrlPhaseSelectLine),
		.ctrlSerialClockLine(link.ctrlSerialClockLine), .hostDataOe(link.hostDataOe), .devDataOe(link.devDataOe));

	always #2.5 clk = ~clk;

	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Bits are taken off the resolved wire at each serial clock rise, first in time ends up leftmost.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		sclkPrev <= link.ctrlSerialClockLine;
		if (link.ctrlSerialClockLine && !sclkPrev) begin
			bits <= {bits[46:0], link.ctrlSerialDataLine};
			nbits <= nbits + 1;
		end
		if (regWrStrobe === 1'b1) begin
			mem[regWrAddr] <= regWrData;
			wrCount <= wrCount + 1;
		end
		if (cycles == 20000) begin
			err_count++;
			print_verdict();
		end
	end

	task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	task automatic run(input logic rd, input logic sel, input logic [6:0] a, input logic [15:0] d);
		int n;
		@(posedge clk);
		nbits <= 0;
		cmdStart <= 1'b1;
		cmdRead <= rd;
		cmdAddrSelect <= sel;
		cmdRegAddr <= a;
		cmdWriteData <= d;
		@(posedge clk);
		cmdStart <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		chk("done", 48'h1, {47'h0, done});
	endtask

	// One write then one read back; a miss leaves the line to its pull-up, so the host reads all ones.
	task automatic xfer(input logic sel, input logic [6:0] a, input logic [15:0] d);
		logic hit;
		logic fl;
		logic [6:0] ea;
		logic [15:0] ed;
		int w;
		hit = (addressSelectPin === sel);
		fl = hit ? (a >= 7'h60) : 1'b1;
		ea = hit ? a : 7'h7F;
		ed = hit ? d : 16'hFFFF;
		w = wrCount;
		run(1'b0, sel, a, d);
		repeat (4) @(negedge clk);
		chk("write wire bits", {TYPE_WRITE, sel, DEV_ADDR_FIXED, RW_WRITE, a, d}, bits[31:0]);
		chk("write bit count", 48'h20, nbits);
		chk("write strobes", w + int'(hit), wrCount);
		if (hit) begin
			chk("written reg", {a, d}, {regWrAddr, regWrData});
		end
		run(1'b1, sel, a, 16'h0000);
		chk("read wire bits", {TYPE_WRITE, sel, DEV_ADDR_FIXED, RW_READ, a, TYPE_READ, sel, DEV_ADDR_FIXED,
			fl, ea, ed}, bits);
		chk("read answer", {fl, ea, ed}, {rspInvalid, rspRegAddr, rspData});
		chk("read strobes", w + int'(hit), wrCount);
		if (hit) begin
			chk("prepared addr", a, regRdAddr);
		end
		$display("test sel %0d addr %h finished", sel, a);
	endtask

	initial begin
		foreach (mem[i]) mem[i] = 16'h0000;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (int p = 0; p < 2; p++) begin
			addressSelectPin <= p[0];
			repeat (4) @(posedge clk);
			xfer(p[0], 7'h00, 16'hA5C3);
			xfer(p[0], 7'h5F, 16'h3C5A);
			xfer(p[0], 7'h60, 16'h0FF0);
			xfer(~p[0], 7'h12, 16'h8001);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
